// ===== cgb_pkg.sv
// package of constants for the clock generator control bank
package cgb_pkg;
  // byte offsets
  localparam logic [7:0] OFS_GATE = 8'h00;
  localparam logic [7:0] OFS_SPREAD = 8'h01;
  localparam logic [7:0] OFS_EDGE = 8'h02;
  localparam logic [7:0] OFS_REF = 8'h03;
  localparam logic [7:0] OFS_SPARE = 8'h04;
  localparam logic [7:0] OFS_REV = 8'h05;
  localparam logic [7:0] OFS_KIND = 8'h06;
  localparam logic [7:0] OFS_LEN = 8'h07;
  localparam logic [7:0] NUM_BYTES = 8'h08;
  // reset values, reserved bits carry their fixed read value
  localparam logic [7:0] RST_GATE = 8'hDD;
  localparam logic [5:0] RST_SPREAD = 6'h06;
  localparam logic [7:0] RST_EDGE = 8'hDD;
  localparam logic [7:0] RST_REF = 8'h5D;
  localparam logic [7:0] RST_SPARE = 8'h00;
  localparam logic [7:0] RST_LEN = 8'h08;
  // writable bit masks
  localparam logic [7:0] WM_GATE = 8'hDD;
  localparam logic [5:0] WM_SPREAD = 6'h3B;
  localparam logic [7:0] WM_EDGE = 8'hDD;
  localparam logic [7:0] WM_REF = 8'hF0;
  localparam logic [7:0] WM_LEN = 8'h1F;
  // field positions
  localparam int STRAP_LO = 6;
  localparam int SPR_OVR_BIT = 5;
  localparam int SPR_SEL_LO = 3;
  localparam int AMP_LO = 0;
  localparam int REF_EDGE_LO = 6;
  localparam int REF_WAKE_BIT = 5;
  localparam int REF_OE_BIT = 4;
  // strap and spread codes
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h3;
  localparam logic [1:0] SPR_OFF = 2'h0;
  localparam logic [1:0] SPR_QUARTER = 2'h1;
  localparam logic [1:0] SPR_HALF = 2'h3;
  // serial byte phases of the link engine
  typedef enum logic [2:0] {
    PH_ADDR = 3'b000,
    PH_INDEX = 3'b001,
    PH_COUNT = 3'b010,
    PH_WDATA = 3'b011,
    PH_RSTART = 3'b100,
    PH_RDATA = 3'b101,
    PH_IGNORE = 3'b110
  } cgb_phase_e;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
endpackage

// ===== cgb_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module cgb_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      q_o <= '0;
    end
    else if (ce_i)
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ===== cgb_link.sv
// serial byte engine on the bus clock: indexed block write and read
`timescale 1ns/1ps
`default_nettype none
module cgb_link #(
  parameter logic [6:0] ADDR_STRAP0 = 7'h50,
  parameter logic [6:0] ADDR_STRAP1 = 7'h51
) (
  input wire logic link_clk_i,
  input wire logic por_rst_i,
  input wire logic idle_rst_i,
  input wire logic restart_rst_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  input wire logic addr_strap_i,
  input wire logic snap_req_i,
  input wire logic [63:0] snap_i,
  output logic snap_ack_o,
  output logic wr_toggle_o,
  output logic [7:0] wr_idx_o,
  output logic [7:0] wr_data_o
);
  logic frame_rst;
  logic phase_rst;
  logic req_s;
  logic strap_s;
  logic [3:0] cnt_reg;
  logic [6:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [63:0] snap_reg;
  logic [7:0] rx;
  logic [6:0] my_addr;
  logic byte_done;
  logic ack_edge;
  logic drive_low;
  cgb_pkg::cgb_phase_e phase_reg;

  assign frame_rst = por_rst_i | idle_rst_i;
  assign phase_rst = frame_rst | restart_rst_i;
  assign rx = {shift_reg, sda_i};
  assign my_addr = strap_s ? ADDR_STRAP1 : ADDR_STRAP0;
  assign byte_done = (cnt_reg == cgb_pkg::LAST_BIT);
  assign ack_edge = (cnt_reg == cgb_pkg::ACK_SLOT);

  cgb_sync #(.W(2)) u_sync (
    .clk_i(link_clk_i),
    .rst_i(por_rst_i),
    .ce_i(1'b1),
    .d_i({snap_req_i, addr_strap_i}),
    .q_o({req_s, strap_s})
  );

  // byte of the snapshot at an index, unmapped indexes read zero
  function automatic logic [7:0] pick(input logic [63:0] s, input logic [7:0] i);
    pick = (i < cgb_pkg::NUM_BYTES) ? s[{i[2:0], 3'b000} +: 8] : 8'h00;
  endfunction

  // snapshot capture, completes the handshake with the register side;
  // reset without a clock edge, since the bus clock stands still during reset
  always_ff @(posedge link_clk_i or posedge por_rst_i)
  begin
    if (por_rst_i)
    begin
      snap_reg <= '0;
      snap_ack_o <= 1'b0;
    end
    else if (req_s != snap_ack_o)
    begin
      snap_reg <= snap_i;
      snap_ack_o <= req_s;
    end
  end

  // bit counter, shifter and byte phase; a repeated start restarts them
  always_ff @(posedge link_clk_i or posedge phase_rst)
  begin
    if (phase_rst)
    begin
      cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      tx_reg <= 8'h00;
      phase_reg <= cgb_pkg::PH_ADDR;
    end
    else if (!ack_edge)
    begin
      shift_reg <= rx[6:0];
      cnt_reg <= cnt_reg + 4'h1;
      if (byte_done)
      begin
        case (phase_reg)
          cgb_pkg::PH_ADDR:
            if (rx[7:1] != my_addr)
              phase_reg <= cgb_pkg::PH_IGNORE;
            else if (rx[0])
              phase_reg <= cgb_pkg::PH_RSTART;
            else
              phase_reg <= cgb_pkg::PH_INDEX;
          cgb_pkg::PH_INDEX: phase_reg <= cgb_pkg::PH_COUNT;
          cgb_pkg::PH_COUNT: phase_reg <= cgb_pkg::PH_WDATA;
          default: phase_reg <= phase_reg;
        endcase
      end
    end
    else
    begin
      cnt_reg <= 4'h0;
      case (phase_reg)
        // after our acknowledge of the read address, the count goes first
        cgb_pkg::PH_RSTART:
        begin
          phase_reg <= cgb_pkg::PH_RDATA;
          tx_reg <= pick(snap_reg, cgb_pkg::OFS_LEN);
        end
        // host nack ends the read, otherwise the next byte is loaded
        cgb_pkg::PH_RDATA:
        begin
          if (sda_i)
            phase_reg <= cgb_pkg::PH_IGNORE;
          else
            tx_reg <= pick(snap_reg, ptr_reg);
        end
        default: phase_reg <= phase_reg;
      endcase
    end
  end

  // byte index survives a repeated start, a stop clears it
  always_ff @(posedge link_clk_i or posedge frame_rst)
  begin
    if (frame_rst)
      ptr_reg <= 8'h00;
    else if (byte_done && phase_reg == cgb_pkg::PH_INDEX)
      ptr_reg <= rx;
    else if (byte_done && phase_reg == cgb_pkg::PH_WDATA)
      ptr_reg <= ptr_reg + 8'h01;
    else if (ack_edge && phase_reg == cgb_pkg::PH_RDATA && !sda_i)
      ptr_reg <= ptr_reg + 8'h01;
  end

  // write event to the register side; toggle only reset at power on
  always_ff @(posedge link_clk_i or posedge por_rst_i)
  begin
    if (por_rst_i)
    begin
      wr_toggle_o <= 1'b0;
      wr_idx_o <= 8'h00;
      wr_data_o <= 8'h00;
    end
    else if (byte_done && phase_reg == cgb_pkg::PH_WDATA)
    begin
      wr_idx_o <= ptr_reg;
      wr_data_o <= rx;
      wr_toggle_o <= ~wr_toggle_o;
    end
  end

  // pull low for our ack slot or a zero data bit
  always_comb
  begin
    drive_low = 1'b0;
    if (ack_edge)
      drive_low = (phase_reg == cgb_pkg::PH_INDEX) || (phase_reg == cgb_pkg::PH_COUNT) ||
                  (phase_reg == cgb_pkg::PH_WDATA) || (phase_reg == cgb_pkg::PH_RSTART);
    else if (phase_reg == cgb_pkg::PH_RDATA)
      drive_low = ~tx_reg[3'h7 - cnt_reg[2:0]];
  end

  // data changes only while the bus clock is low
  always_ff @(negedge link_clk_i or posedge phase_rst)
  begin
    if (phase_rst)
      sda_oe_o <= 1'b0;
    else
      sda_oe_o <= drive_low;
  end
endmodule
`default_nettype wire

// ===== cgb_bank.sv
// control and identification register bank with serial access
`timescale 1ns/1ps
`default_nettype none
module cgb_bank #(
  parameter logic [3:0] REVISION_ID = 4'h3, // arbitrary value
  parameter logic [3:0] MAKER_ID = 4'hA, // arbitrary value
  parameter logic [1:0] PART_TYPE = 2'h2, // arbitrary value
  parameter logic [5:0] PART_NUMBER = 6'h15, // arbitrary value
  parameter logic [6:0] ADDR_STRAP0 = 7'h50,
  parameter logic [6:0] ADDR_STRAP1 = 7'h51
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic bus_addr_strap_i,
  input wire logic [1:0] spread_strap_i,
  input wire logic [5:0] diff_enable_n_i,
  input wire logic power_down_i,
  output logic [5:0] diff_run_o,
  output logic [5:0] edge_rate_sel_o,
  output logic [1:0] amplitude_sel_o,
  output logic [1:0] spread_sel_o,
  output logic ref_run_o,
  output logic [1:0] ref_edge_sel_o
);
  logic [7:0] gate_reg;
  logic [5:0] spread_reg;
  logic [7:0] edge_reg;
  logic [7:0] ref_reg;
  logic [7:0] len_reg;
  logic [1:0] strap_reg;
  logic addr_strap_reg;
  logic [1:0] strap_cnt_reg;
  logic scl_d_reg;
  logic scl_d2_reg;
  logic idle_reg;
  logic restart_reg;
  logic por_reg;
  logic sda_d_reg;
  logic wr_seen_reg;
  logic snap_req_reg;
  logic [63:0] snap_reg;
  logic [63:0] live_bytes;
  logic scl_s;
  logic sda_s;
  logic snap_ack_s;
  logic wr_tog_s;
  logic [1:0] spread_strap_s;
  logic addr_strap_s;
  logic [5:0] enable_n_s;
  logic power_down_s;
  logic wr_toggle;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic snap_ack;
  logic start_seen;
  logic stop_seen;
  logic wr_event;

  // pins and link-side handshake bits come in through two flops
  cgb_sync #(.W(14)) u_pin_sync (
    .clk_i(mclk_i),
    .rst_i(reset_i),
    .ce_i(ce_i),
    .d_i({link_clk_i, sda_i, snap_ack, wr_toggle, spread_strap_i, bus_addr_strap_i,
          diff_enable_n_i, power_down_i}),
    .q_o({scl_s, sda_s, snap_ack_s, wr_tog_s, spread_strap_s, addr_strap_s,
          enable_n_s, power_down_s})
  );

  cgb_link #(
    .ADDR_STRAP0(ADDR_STRAP0),
    .ADDR_STRAP1(ADDR_STRAP1)
  ) u_link (
    .link_clk_i(link_clk_i),
    .por_rst_i(por_reg),
    .idle_rst_i(idle_reg),
    .restart_rst_i(restart_reg),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .addr_strap_i(addr_strap_reg),
    .snap_req_i(snap_req_reg),
    .snap_i(snap_reg),
    .snap_ack_o(snap_ack),
    .wr_toggle_o(wr_toggle),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data)
  );

  // six output bits sit at positions 7,6,4,3,2,0 of a byte
  function automatic logic [5:0] squeeze(input logic [7:0] b);
    squeeze = {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction

  // masked update keeps read-only and reserved bits fixed
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d, input logic [7:0] m);
    merge = (old & ~m) | (d & m);
  endfunction

  // a data bit keeps the bus clock high for less than one mclk period, so only a clock seen high
  // on three samples in a row marks a start or stop; data moving in the low phase never does
  assign start_seen = scl_s & scl_d_reg & scl_d2_reg & sda_d_reg & ~sda_s;
  assign stop_seen = scl_s & scl_d_reg & scl_d2_reg & ~sda_d_reg & sda_s;
  assign wr_event = (wr_tog_s != wr_seen_reg);

  // bus frame tracking from the synchronised pins
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sda_d_reg <= 1'b1;
      scl_d_reg <= 1'b0;
      scl_d2_reg <= 1'b0;
      idle_reg <= 1'b1;
      restart_reg <= 1'b0;
      por_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      por_reg <= 1'b0;
      sda_d_reg <= sda_s;
      scl_d_reg <= scl_s;
      scl_d2_reg <= scl_d_reg;
      restart_reg <= start_seen & ~idle_reg;
      if (stop_seen)
        idle_reg <= 1'b1;
      else if (start_seen)
        idle_reg <= 1'b0;
    end
  end

  // straps are caught over the first three enabled cycles after reset, so the zeros
  // that reset left in the synchroniser have flushed out before the last capture
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      strap_cnt_reg <= 2'h0;
      strap_reg <= cgb_pkg::STRAP_LOW;
      addr_strap_reg <= 1'b0;
    end
    else if (ce_i && strap_cnt_reg != 2'h3)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      strap_reg <= spread_strap_s;
      addr_strap_reg <= addr_strap_s;
    end
  end

  // register writes arrive as a toggle with index and data held steady
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wr_seen_reg <= 1'b0;
      gate_reg <= cgb_pkg::RST_GATE;
      spread_reg <= cgb_pkg::RST_SPREAD;
      edge_reg <= cgb_pkg::RST_EDGE;
      ref_reg <= cgb_pkg::RST_REF;
      len_reg <= cgb_pkg::RST_LEN;
    end
    else if (ce_i && wr_event)
    begin
      wr_seen_reg <= wr_tog_s;
      case (wr_idx)
        cgb_pkg::OFS_GATE: gate_reg <= merge(gate_reg, wr_data, cgb_pkg::WM_GATE);
        cgb_pkg::OFS_SPREAD:
          spread_reg <= (spread_reg & ~cgb_pkg::WM_SPREAD) | (wr_data[5:0] & cgb_pkg::WM_SPREAD);
        cgb_pkg::OFS_EDGE: edge_reg <= merge(edge_reg, wr_data, cgb_pkg::WM_EDGE);
        cgb_pkg::OFS_REF: ref_reg <= merge(ref_reg, wr_data, cgb_pkg::WM_REF);
        cgb_pkg::OFS_LEN: len_reg <= merge(len_reg, wr_data, cgb_pkg::WM_LEN);
        default: gate_reg <= gate_reg; // spare and id bytes drop writes
      endcase
    end
  end

  // read image of all eight bytes, byte 0 in the low lane
  always_comb
  begin
    live_bytes = {len_reg,
                  PART_TYPE, PART_NUMBER,
                  REVISION_ID, MAKER_ID,
                  cgb_pkg::RST_SPARE,
                  ref_reg, edge_reg,
                  strap_reg, spread_reg,
                  gate_reg};
  end

  // snapshot republished whenever the link side has taken the last one
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      snap_req_reg <= 1'b0;
      snap_reg <= '0;
    end
    else if (ce_i && snap_ack_s == snap_req_reg)
    begin
      snap_reg <= live_bytes;
      snap_req_reg <= ~snap_req_reg;
    end
  end

  // differential pair control; a cleared gate bit overrides the pin
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      diff_run_o <= 6'h00;
      edge_rate_sel_o <= squeeze(cgb_pkg::RST_EDGE);
      amplitude_sel_o <= cgb_pkg::RST_SPREAD[cgb_pkg::AMP_LO +: 2];
    end
    else if (ce_i)
    begin
      diff_run_o <= squeeze(gate_reg) & ~enable_n_s;
      edge_rate_sel_o <= squeeze(edge_reg);
      amplitude_sel_o <= spread_reg[cgb_pkg::AMP_LO +: 2];
    end
  end

  // spread amount: software field only counts under override
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      spread_sel_o <= cgb_pkg::SPR_OFF;
    else if (ce_i)
    begin
      if (spread_reg[cgb_pkg::SPR_OVR_BIT])
        spread_sel_o <= spread_reg[cgb_pkg::SPR_SEL_LO +: 2];
      else if (strap_reg == cgb_pkg::STRAP_HIGH)
        spread_sel_o <= cgb_pkg::SPR_HALF;
      else if (strap_reg == cgb_pkg::STRAP_MID)
        spread_sel_o <= cgb_pkg::SPR_QUARTER;
      else
        spread_sel_o <= cgb_pkg::SPR_OFF;
    end
  end

  // reference output: enable, wake-in-power-down and edge rate
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ref_run_o <= 1'b0;
      ref_edge_sel_o <= cgb_pkg::RST_REF[cgb_pkg::REF_EDGE_LO +: 2];
      sda_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ref_run_o <= ref_reg[cgb_pkg::REF_OE_BIT] &
                   (~power_down_s | ref_reg[cgb_pkg::REF_WAKE_BIT]);
      ref_edge_sel_o <= ref_reg[cgb_pkg::REF_EDGE_LO +: 2];
      sda_o <= 1'b0; // open drain: only the enable ever changes
    end
  end
endmodule
`default_nettype wire

// ===== cgb_bank_monitor.sv
// checker for the control bank outputs and the serial data enable
`timescale 1ns/1ps
`default_nettype none
module cgb_bank_monitor (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic power_down_i,
  input wire logic [5:0] diff_enable_n_i,
  input wire logic [5:0] diff_run_o,
  input wire logic [5:0] edge_rate_sel_o,
  input wire logic [1:0] amplitude_sel_o,
  input wire logic [1:0] spread_sel_o,
  input wire logic ref_run_o,
  input wire logic [1:0] ref_edge_sel_o
);
  logic scl_reg;
  logic [4:0] idle_reg;
  // cycles since the serial clock last moved; a written byte lands long before 20
  always_ff @(posedge mclk_i)
  begin
    scl_reg <= link_clk_i;
    if (reset_i || scl_reg != link_clk_i)
      idle_reg <= 5'h00;
    else if (idle_reg != 5'h1F)
      idle_reg <= idle_reg + 5'h01;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_rst_dflt;
    $fell(reset_i) |-> diff_run_o == 6'h00 && edge_rate_sel_o == 6'h3F && amplitude_sel_o == 2'h2
      && spread_sel_o == 2'h0 && !ref_run_o && ref_edge_sel_o == 2'h1 && !sda_oe_o;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("outputs not at defaults after reset");
  property p_pins_off;
    (ce_i && diff_enable_n_i == 6'h3F) [*8] |-> diff_run_o == 6'h00;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pair runs with its pin off");
  property p_edge_quiet;
    idle_reg > 5'h14 |-> $stable(edge_rate_sel_o);
  endproperty
  a_edge_quiet: assert property (p_edge_quiet) else $error("edge rate moved on idle bus");
  property p_amp_quiet;
    idle_reg > 5'h14 |-> $stable(amplitude_sel_o) && $stable(ref_edge_sel_o);
  endproperty
  a_amp_quiet: assert property (p_amp_quiet) else $error("amplitude or ref edge moved on idle bus");
  property p_spread_quiet;
    idle_reg > 5'h14 |-> $stable(spread_sel_o);
  endproperty
  a_spread_quiet: assert property (p_spread_quiet) else $error("spread moved on idle bus");
  property p_run_hold;
    (idle_reg > 5'h14 && $stable(diff_enable_n_i) && $stable(power_down_i)) [*6]
      |=> $stable(diff_run_o) && $stable(ref_run_o);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run outputs moved without cause");
  property p_sda_low;
    sda_o == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data line driven high");
  property p_bus_free;
    idle_reg > 5'h14 && link_clk_i |-> !sda_oe_o;
  endproperty
  a_bus_free: assert property (p_bus_free) else $error("data line held on idle bus");
  c_amp: cover property ($changed(amplitude_sel_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_block: cover property (diff_run_o == 6'h00 && diff_enable_n_i != 6'h3F);
endmodule
bind cgb_bank cgb_bank_monitor u_mon (.mclk_i, .reset_i, .ce_i, .link_clk_i, .sda_o, .sda_oe_o, .power_down_i,
  .diff_enable_n_i, .diff_run_o, .edge_rate_sel_o, .amplitude_sel_o, .spread_sel_o, .ref_run_o, .ref_edge_sel_o);
`default_nettype wire

// ===== cgb_host_model.sv
// serial host model issuing indexed block writes and reads
`timescale 1ns/1ps
`default_nettype none
module cgb_host (
  input wire logic [6:0] addr_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv;
  logic ack;
  int gap;
  integer nak;
  // open drain with pull-up: low when either side pulls
  assign sda_o = drv & ~sda_oe_i;
  initial
  begin
    scl_o = 1'b1;
    drv = 1'b1;
    gap = 0;
    nak = 0;
  end
  // data changes only in the low phase; gap stretches it for a slow host
  task automatic bitx(input logic b, output logic r);
    #(4 + gap) drv = b;
    #12 scl_o = 1'b1;
    r = sda_o;
    #16 scl_o = 1'b0;
  endtask
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(a, ack);
  endtask
  // start, or repeated start when the clock is low
  task automatic st(input logic again);
    if (again)
    begin
      #4 drv = 1'b1;
      #12 scl_o = 1'b1;
    end
    #100 drv = 1'b0;
    #120 scl_o = 1'b0;
  endtask
  task automatic sp;
    #4 drv = 1'b0;
    #12 scl_o = 1'b1;
    #100 drv = 1'b1;
    #200;
  endtask
  task automatic wr(input logic [7:0] idx, input int n, input logic [7:0] d [8]);
    logic [7:0] q;
    nak = 0;
    st(1'b0);
    xb({addr_i, 1'b0}, 1'b1, q);
    nak += ack;
    xb(idx, 1'b1, q);
    nak += ack;
    xb(n[7:0], 1'b1, q);
    nak += ack;
    for (int k = 0; k < n; k++)
    begin
      xb(d[k], 1'b1, q);
      nak += ack;
    end
    sp();
  endtask
  task automatic rd(input logic [7:0] idx, input int n, output logic [7:0] cnt, output logic [7:0] q [8]);
    st(1'b0);
    xb({addr_i, 1'b0}, 1'b1, cnt);
    xb(idx, 1'b1, cnt);
    st(1'b1);
    xb({addr_i, 1'b1}, 1'b1, cnt);
    xb(8'hFF, 1'b0, cnt);
    for (int k = 0; k < n; k++)
      xb(8'hFF, k == n - 1, q[k]);
    sp();
  endtask
endmodule
`default_nettype wire

// ===== tb_cgb_bank.sv
// self-checking bench for the control bank
`timescale 1ns/1ps
`default_nettype none
module tb_cgb_bank;
  localparam logic [3:0] REV = 4'h7; // arbitrary value
  localparam logic [3:0] MKR = 4'hC; // arbitrary value
  localparam logic [1:0] PTY = 2'h1; // arbitrary value
  localparam logic [5:0] PNO = 6'h2B; // arbitrary value
  logic mclk, rst, bstrap, pd, scl, sda_w, oe, rrun;
  logic [1:0] sstrap, amp, spr, rsel;
  logic [5:0] pins, run, edg;
  logic [6:0] haddr;
  logic [7:0] cnt;
  logic [7:0] sh [8];
  logic [7:0] d [8];
  logic [7:0] q [8];
  int num_errors, tests_run, r;
  cgb_bank #(.REVISION_ID(REV), .MAKER_ID(MKR), .PART_TYPE(PTY), .PART_NUMBER(PNO)) dut (.mclk_i(mclk),
    .reset_i(rst), .ce_i(1'b1), .link_clk_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(oe), .bus_addr_strap_i(bstrap),
    .spread_strap_i(sstrap), .diff_enable_n_i(pins), .power_down_i(pd), .diff_run_o(run), .edge_rate_sel_o(edg),
    .amplitude_sel_o(amp), .spread_sel_o(spr), .ref_run_o(rrun), .ref_edge_sel_o(rsel));
  cgb_host h (.addr_i(haddr), .sda_oe_i(oe), .scl_o(scl), .sda_o(sda_w));
  always #10 mclk = ~mclk;
  // byte read back: reserved bits at fixed values, strap in byte 1
  function automatic logic [7:0] expb(input int i);
    case (i)
      0, 2: return sh[i] & 8'hDD;
      1: return {sstrap, sh[1][5:3], 1'b1, sh[1][1:0]};
      3: return {sh[3][7:4], 4'hD};
      5: return {REV, MKR};
      6: return {PTY, PNO};
      7: return {3'h0, sh[7][4:0]};
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [5:0] map6(input logic [7:0] b);
    return {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic rd_all;
    h.rd(8'h00, 8, cnt, q);
    chk("count", expb(7), cnt);
    for (int i = 0; i < 8; i++)
      chk($sformatf("byte%0d", i), expb(i), q[i]);
  endtask
  // pins pass two flops and a register, so allow settle time
  task automatic chk_out;
    logic [7:0] b1;
    b1 = expb(1);
    repeat (12) @(posedge mclk);
    #1;
    chk("run", {2'h0, map6(expb(0)) & ~pins}, {2'h0, run});
    chk("edge", {2'h0, map6(expb(2))}, {2'h0, edg});
    chk("amp", {6'h0, b1[1:0]}, {6'h0, amp});
    chk("spread", {6'h0, b1[5] ? b1[4:3] : sstrap}, {6'h0, spr});
    chk("refsel", {6'h0, sh[3][7:6]}, {6'h0, rsel});
    chk("refrun", {7'h0, sh[3][4] & (!pd | sh[3][5])}, {7'h0, rrun});
  endtask
  task automatic do_reset;
    @(posedge mclk);
    #2 rst = 1'b1;
    repeat (6) @(posedge mclk);
    #2 rst = 1'b0;
    sh = '{8'hDD, 8'h02, 8'hDD, 8'h5D, 8'h00, 8'h00, 8'h00, 8'h08};
    repeat (8) @(posedge mclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    // some two dozen frames of a few microseconds each; a hang shows long before this
    #1000000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    pins = 6'h00;
    pd = 1'b0;
    num_errors = 0;
    tests_run = 0;
    void'($urandom(34));
    r = $urandom % 3;
    sstrap = {r == 2, r != 0};
    bstrap = 1'($urandom);
    haddr = bstrap ? 7'h51 : 7'h50;
    do_reset();
    chk_out();
    rd_all();
    $display("test defaults done");
    // block writes of all bytes: corners first, then random, some slow
    for (int n = 0; n < 8; n++)
    begin
      for (int k = 0; k < 8; k++)
        d[k] = n == 0 ? 8'h00 : n == 1 ? 8'hFF : 8'($urandom);
      h.gap = (n % 3 == 2) ? 40 : 0;
      h.wr(8'h00, 8, d);
      chk("ack", 8'h00, h.nak[7:0]);
      sh = d;
      @(posedge mclk);
      #2 pins = (n == 2) ? 6'h3F : 6'($urandom);
      pd = 1'($urandom);
      chk_out();
      rd_all();
    end
    $display("test random writes done");
    d[0] = 8'($urandom);
    d[1] = 8'($urandom);
    h.wr(8'h06, 2, d);
    sh[7] = d[1];
    h.rd(8'h05, 3, cnt, q);
    for (int i = 0; i < 3; i++)
      chk("tail", expb(i + 5), q[i]);
    h.rd(8'h08, 1, cnt, q);
    chk("unmapped", 8'h00, q[0]);
    $display("test index edges done");
    haddr = haddr ^ 7'h01;
    d[0] = ~sh[0];
    h.wr(8'h00, 1, d);
    chk("noack", 8'h01, {7'h0, h.nak != 0});
    haddr = haddr ^ 7'h01;
    rd_all();
    $display("test wrong address done");
    do_reset();
    chk_out();
    rd_all();
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
